// ---- rcc_defines.svh ----
`ifndef RCC_DEFINES_SVH
`define RCC_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define RCC_IDX_CONFIG      4'h9
`define RCC_IDX_MASK        4'ha
`define RCC_IDX_POLICY      4'hb
`define RCC_IDX_STATE       4'hc

// ----------------------------------------
// Reset values and writable bits
// ----------------------------------------
`define RCC_CONFIG_RST      16'h0002
`define RCC_CONFIG_WMASK    16'h01bf
`define RCC_MASK_RST        16'h0000
`define RCC_MASK_WMASK      16'h2ffe
`define RCC_POLICY_RST      16'h0000
`define RCC_POLICY_WMASK    16'h003f
`define RCC_STATE_RST       16'h0000
`define RCC_STATE_WMASK     16'h0003

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RCC_POLE_LSB        7
`define RCC_FREQ_LSB        3
`define RCC_BOOST_LSB       0
`define RCC_LEAVE_BIT       0
`define RCC_MONMASK_BIT     1
`define RCC_CALMASK_BIT     2
`define RCC_IUVMASK_BIT     3
`define RCC_IOVMASK_BIT     4
`define RCC_XUVMASK_BIT     5
`define RCC_XOVMASK_BIT     6
`define RCC_LOOPMASK_BIT    7
`define RCC_COLMASK_BIT     8
`define RCC_SOLMASK_BIT     9
`define RCC_COHMASK_BIT     10
`define RCC_SOHMASK_BIT     11
`define RCC_SHORTMASK_BIT   13
`define RCC_KEEPUV_BIT      0
`define RCC_KEEPMON_BIT     1
`define RCC_KEEPBIST_BIT    2
`define RCC_KEEPIO_BIT      3
`define RCC_KEEPIN_BIT      4
`define RCC_FEOFF_BIT       5
`define RCC_LBIST_BIT       14
`define RCC_ABIST_BIT       15
`define RCC_EXC_BIT         0
`define RCC_LOOP_BIT        1
`define RCC_ENTER_BIT       2

// ----------------------------------------
// Self-test run lengths in cycles
// ----------------------------------------
`define RCC_ABIST_CYCLES    8'd64
`define RCC_LBIST_CYCLES    8'd32

`endif

// ---- rcc_pkg.sv ----
package rcc_pkg;
    typedef enum logic [1:0] {
        RCC_CHECK  = 2'b01,
        RCC_NORMAL = 2'b10
    } rcc_state_e;
    typedef logic [15:0] rcc_word_t;
endpackage

// ---- resolver_config_control_regs.sv ----
`timescale 1ns/1ps
`include "rcc_defines.svh"

// Notes on behaviour
// - Two-bit pole multiplier selects one to four
// - Three-bit exciter frequency code, internal clock only
// - Boost voltage code, 10 V upward, resets two
// - Short and open fault masks, reset zero
// - Loop error, exciter over/under masks
// - Input overvoltage and undervoltage masks
// - Calibration mask; monitor mask covers both
// - Leave-check write exits; self-clears, reads zero
// - Leave-check bit ignores write protection
// - Checksum sees zero for leave and selftest
// - Analog selftest launch; reads running indicator
// - Logic selftest launch; reads running indicator
// - Front-end off bit disables converter front
// - Input faults stop exciter unless kept
// - Digital pin fault stops exciter unless kept
// - Selftest failure stops exciter unless kept
// - Monitor faults stop exciter unless kept
// - Exciter undervoltage stops exciter unless kept
// - Enter-check write enters; self-clears, reads zero
// - Unmasked unkept fault, except loop error and calibration, clears exciter on while active
// - Loop and exciter on set on first entry to normal
module resolver_config_control_regs
    import rcc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        writeProtect,
    input  wire logic        externalClockSelect,
    input  wire logic        inputShortFlag,
    input  wire logic        sineOpenHighFlag,
    input  wire logic        cosineOpenHighFlag,
    input  wire logic        sineOpenLowFlag,
    input  wire logic        cosineOpenLowFlag,
    input  wire logic        loopErrorFlag,
    input  wire logic        exciterOvervoltFlag,
    input  wire logic        exciterUndervoltFlag,
    input  wire logic        inputOvervoltFlag,
    input  wire logic        inputUndervoltFlag,
    input  wire logic        calibrationFault,
    input  wire logic        exciterMonitorHighFlag,
    input  wire logic        exciterMonitorLowFlag,
    input  wire logic        digitalPinFault,
    input  wire logic        selftestFail,
    output logic      [2:0]  poleMultiplier,
    output logic      [2:0]  exciterFreqSelect,
    output logic             exciterFreqValid,
    output logic      [2:0]  boostVoltageSelect,
    output logic             converterFrontEndOff,
    output logic             trackingLoopOn,
    output logic             exciterOn,
    output logic             selfCheckState,
    output logic             analogSelftestRunning,
    output logic             logicSelftestRunning,
    output logic             faultActive,
    output logic      [15:0] checksum
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    rcc_word_t  configReg;
    rcc_word_t  maskReg;
    rcc_word_t  policyReg;
    logic       loopReg;
    logic       excReg;
    rcc_state_e stateReg;
    logic [7:0] abistCntReg;
    logic [7:0] lbistCntReg;
    logic       ackReg;
    logic [31:0] datReg;
    logic       poweredReg;
    logic       checkStateReg;
    logic       abistRunReg;
    logic       lbistRunReg;

    // Byte-lane merge of a 16-bit register
    function automatic rcc_word_t merge(input rcc_word_t old, input rcc_word_t wd,
                                        input logic [1:0] sel, input rcc_word_t wm);
        rcc_word_t lane;
        lane  = {{8{sel[1]}}, {8{sel[0]}}} & wm;
        merge = (old & ~lane) | (wd & lane);
    endfunction

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire        busReq     = wb_cyc_i && wb_stb_i && !ackReg;
    wire        wrStrobe   = busReq && wb_we_i;
    wire [3:0]  regIdx     = wb_adr_i[5:2];
    wire        hitConfig  = regIdx == `RCC_IDX_CONFIG;
    wire        hitMask    = regIdx == `RCC_IDX_MASK;
    wire        hitPolicy  = regIdx == `RCC_IDX_POLICY;
    wire        hitState   = regIdx == `RCC_IDX_STATE;
    wire        wrAllowed  = wrStrobe && !writeProtect;
    wire [15:0] wrData     = wb_dat_i[15:0];
    wire        lowLane    = wb_sel_i[0];
    wire        highLane   = wb_sel_i[1];
    wire [1:0]  laneSel    = wb_sel_i[1:0];

    wire leaveCmd  = wrStrobe && hitMask && lowLane && wrData[`RCC_LEAVE_BIT];
    wire enterCmd  = wrAllowed && hitState && lowLane && wrData[`RCC_ENTER_BIT];
    wire abistCmd  = wrAllowed && hitPolicy && highLane && wrData[`RCC_ABIST_BIT];
    wire lbistCmd  = wrAllowed && hitPolicy && highLane && wrData[`RCC_LBIST_BIT];

    // ----------------------------------------
    // Fault gating
    // ----------------------------------------
    wire inputFault = (inputShortFlag     && !maskReg[`RCC_SHORTMASK_BIT])
                   || (sineOpenHighFlag   && !maskReg[`RCC_SOHMASK_BIT])
                   || (cosineOpenHighFlag && !maskReg[`RCC_COHMASK_BIT])
                   || (sineOpenLowFlag    && !maskReg[`RCC_SOLMASK_BIT])
                   || (cosineOpenLowFlag  && !maskReg[`RCC_COLMASK_BIT])
                   || (inputOvervoltFlag  && !maskReg[`RCC_IOVMASK_BIT])
                   || (inputUndervoltFlag && !maskReg[`RCC_IUVMASK_BIT]);
    wire monFault  = (exciterMonitorHighFlag || exciterMonitorLowFlag)
                   && !maskReg[`RCC_MONMASK_BIT];
    wire uvFault   = exciterUndervoltFlag && !maskReg[`RCC_XUVMASK_BIT];
    wire ovFault   = exciterOvervoltFlag && !maskReg[`RCC_XOVMASK_BIT];
    wire loopFault = loopErrorFlag && !maskReg[`RCC_LOOPMASK_BIT];
    wire calFault  = calibrationFault && !maskReg[`RCC_CALMASK_BIT];

    wire excKill = (inputFault && !policyReg[`RCC_KEEPIN_BIT])
                || (digitalPinFault && !policyReg[`RCC_KEEPIO_BIT])
                || (selftestFail && !policyReg[`RCC_KEEPBIST_BIT])
                || (monFault && !policyReg[`RCC_KEEPMON_BIT])
                || (uvFault && !policyReg[`RCC_KEEPUV_BIT])
                || ovFault;
    wire anyFault = inputFault || monFault || uvFault || ovFault || loopFault || calFault
                 || digitalPinFault || selftestFail;

    // ----------------------------------------
    // Next-state terms
    // ----------------------------------------
    wire        toNormal   = stateReg == RCC_CHECK && leaveCmd;
    wire        autoEnable = toNormal && !poweredReg;
    wire        wrCtl      = wrAllowed && hitState && lowLane;
    wire        loopNext   = excKill ? 1'b0 : autoEnable ? 1'b1
                           : wrCtl ? wrData[`RCC_LOOP_BIT] : loopReg;
    wire        excNext    = excKill ? 1'b0 : autoEnable ? 1'b1
                           : wrCtl ? wrData[`RCC_EXC_BIT] : excReg;
    wire [7:0]  abistNext  = abistCmd ? `RCC_ABIST_CYCLES
                           : (abistCntReg != 8'h00) ? abistCntReg - 8'h01 : 8'h00;
    wire [7:0]  lbistNext  = lbistCmd ? `RCC_LBIST_CYCLES
                           : (lbistCntReg != 8'h00) ? lbistCntReg - 8'h01 : 8'h00;
    wire [15:0] stateRead  = {14'h0000, loopReg, excReg};
    wire [15:0] policyRead = {abistCntReg != 8'h00, lbistCntReg != 8'h00,
                              8'h00, policyReg[5:0]};
    wire [15:0] readMux    = hitConfig ? configReg
                           : hitMask   ? maskReg
                           : hitPolicy ? policyRead
                           : hitState  ? stateRead : 16'h0000;
    wire [15:0] configWr   = merge(configReg, wrData, laneSel, `RCC_CONFIG_WMASK);
    wire [15:0] maskWr     = merge(maskReg, wrData, laneSel, `RCC_MASK_WMASK);
    wire [15:0] policyWr   = merge(policyReg, wrData, laneSel, `RCC_POLICY_WMASK);
    wire rcc_state_e stateNext = toNormal ? RCC_NORMAL
        : (stateReg == RCC_NORMAL && enterCmd) ? RCC_CHECK : stateReg;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            configReg <= `RCC_CONFIG_RST;
            maskReg   <= `RCC_MASK_RST;
            policyReg <= `RCC_POLICY_RST;
        end else if (wrAllowed) begin
            if (hitConfig) configReg <= configWr;
            if (hitMask)   maskReg   <= maskWr;
            if (hitPolicy) policyReg <= policyWr;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stateReg   <= RCC_CHECK;
            checkStateReg <= 1'b1;
            poweredReg <= 1'b0;
            loopReg    <= 1'b0;
            excReg     <= 1'b0;
        end else begin
            stateReg   <= stateNext;
            checkStateReg <= stateNext == RCC_CHECK;
            poweredReg <= poweredReg || toNormal;
            loopReg    <= loopNext;
            excReg     <= excNext;
        end
    end

    // Both self-tests start automatically at power-up
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            abistCntReg <= `RCC_ABIST_CYCLES;
            lbistCntReg <= `RCC_LBIST_CYCLES;
            abistRunReg <= 1'b1;
            lbistRunReg <= 1'b1;
        end else begin
            abistCntReg <= abistNext;
            lbistCntReg <= lbistNext;
            abistRunReg <= abistNext != 8'h00;
            lbistRunReg <= lbistNext != 8'h00;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ackReg <= 1'b0;
            datReg <= 32'h0000_0000;
        end else begin
            ackReg <= busReq;
            datReg <= busReq && !wb_we_i ? {16'h0000, readMux} : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            poleMultiplier        <= 3'h1;
            exciterFreqSelect     <= 3'h0;
            exciterFreqValid      <= 1'b0;
            boostVoltageSelect    <= 3'h2;
            converterFrontEndOff  <= 1'b0;
            faultActive           <= 1'b0;
            checksum              <= 16'h0000;
        end else begin
            poleMultiplier        <= {1'b0, configReg[`RCC_POLE_LSB +: 2]} + 3'h1;
            exciterFreqSelect     <= configReg[`RCC_FREQ_LSB +: 3];
            exciterFreqValid      <= !externalClockSelect;
            boostVoltageSelect    <= configReg[`RCC_BOOST_LSB +: 3];
            converterFrontEndOff  <= policyReg[`RCC_FEOFF_BIT];
            faultActive           <= anyFault;
            checksum              <= configReg ^ {maskReg[15:1], 1'b0}
                                   ^ {2'b00, policyReg[13:0]}
                                   ^ {14'h0000, loopReg, excReg};
        end
    end

    assign wb_ack_o              = ackReg;
    assign wb_dat_o              = datReg;
    assign trackingLoopOn        = loopReg;
    assign exciterOn             = excReg;
    assign selfCheckState        = checkStateReg;
    assign analogSelftestRunning = abistRunReg;
    assign logicSelftestRunning  = lbistRunReg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence leaveWrite;
        stateReg == RCC_CHECK && leaveCmd;
    endsequence

    sequence busTake;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence ackPulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_exit_check_state: assert property (@(posedge clock) disable iff (!arst_n)
        leaveWrite |=> stateReg == RCC_NORMAL)
        else $error("leave write did not reach normal state");
    a_exit_unprotected: assert property (@(posedge clock) disable iff (!arst_n)
        (leaveWrite and writeProtect) |=> !selfCheckState)
        else $error("protected leave write ignored");
    a_enter_check_state: assert property (@(posedge clock) disable iff (!arst_n)
        stateReg == RCC_NORMAL && enterCmd |=> selfCheckState)
        else $error("enter write did not reach check state");
    a_kill_exciter: assert property (@(posedge clock) disable iff (!arst_n)
        excKill |=> !exciterOn)
        else $error("exciter on during unmasked fault");
    a_undervolt_keep: assert property (@(posedge clock) disable iff (!arst_n)
        uvFault && !policyReg[`RCC_KEEPUV_BIT] |=> !exciterOn)
        else $error("undervoltage did not stop exciter");
    a_auto_enable: assert property (@(posedge clock) disable iff (!arst_n)
        autoEnable && !excKill |=> exciterOn && trackingLoopOn)
        else $error("enables not set on first normal entry");
    a_abist_runs: assert property (@(posedge clock) disable iff (!arst_n)
        abistCmd |=> analogSelftestRunning [*8])
        else $error("analog selftest indicator dropped early");
    a_lbist_runs: assert property (@(posedge clock) disable iff (!arst_n)
        lbistCmd |=> logicSelftestRunning [*8])
        else $error("logic selftest indicator dropped early");
    a_leave_reads_zero: assert property (@(posedge clock) disable iff (!arst_n)
        !maskReg[`RCC_LEAVE_BIT] && !maskReg[12] && !maskReg[15])
        else $error("reserved or self-clearing bit stored");
    a_front_end_off: assert property (@(posedge clock) disable iff (!arst_n)
        ##1 converterFrontEndOff == $past(policyReg[`RCC_FEOFF_BIT]))
        else $error("front end off does not follow register");

    a_ack_one_cycle: assert property (@(posedge clock) disable iff (!arst_n)
        busTake |=> ackPulse)
        else $error("bus answer is not a single ack cycle");
    a_read_data_idle: assert property (@(posedge clock) disable iff (!arst_n)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data present outside ack cycle");
    a_protect_config: assert property (@(posedge clock) disable iff (!arst_n)
        writeProtect && wrStrobe && hitConfig |=> configReg == $past(configReg))
        else $error("protected config write changed register");
    a_loop_killed: assert property (@(posedge clock) disable iff (!arst_n)
        excKill |=> !trackingLoopOn)
        else $error("tracking loop on during exciter fault");
    a_pole_follows: assert property (@(posedge clock) disable iff (!arst_n)
        ##1 poleMultiplier == {1'b0, $past(configReg[`RCC_POLE_LSB +: 2])} + 3'h1)
        else $error("pole multiplier does not follow code");
    a_freq_follows: assert property (@(posedge clock) disable iff (!arst_n)
        ##1 exciterFreqSelect == $past(configReg[`RCC_FREQ_LSB +: 3]))
        else $error("exciter frequency does not follow code");
    a_boost_follows: assert property (@(posedge clock) disable iff (!arst_n)
        ##1 boostVoltageSelect == $past(configReg[`RCC_BOOST_LSB +: 3]))
        else $error("boost select does not follow code");
    a_input_kill: assert property (@(posedge clock) disable iff (!arst_n)
        inputFault && !policyReg[`RCC_KEEPIN_BIT] |=> !exciterOn)
        else $error("input fault did not stop exciter");
    a_io_kill: assert property (@(posedge clock) disable iff (!arst_n)
        digitalPinFault && !policyReg[`RCC_KEEPIO_BIT] |=> !exciterOn)
        else $error("digital pin fault did not stop exciter");
    a_bist_kill: assert property (@(posedge clock) disable iff (!arst_n)
        selftestFail && !policyReg[`RCC_KEEPBIST_BIT] |=> !exciterOn)
        else $error("selftest failure did not stop exciter");
    a_monitor_kill: assert property (@(posedge clock) disable iff (!arst_n)
        monFault && !policyReg[`RCC_KEEPMON_BIT] |=> !exciterOn)
        else $error("monitor fault did not stop exciter");
    a_exciter_holds: assert property (@(posedge clock) disable iff (!arst_n)
        !excKill && !autoEnable && !wrCtl |=> exciterOn == $past(exciterOn))
        else $error("exciter on changed without cause");
    a_exciter_write: assert property (@(posedge clock) disable iff (!arst_n)
        wrCtl && !excKill && !autoEnable |=> exciterOn == $past(wrData[`RCC_EXC_BIT]))
        else $error("exciter on did not take written value");

endmodule

// ---- resolver_config_control_regs_bench.sv ----
`timescale 1ns/1ps
`include "rcc_defines.svh"

module resolver_config_control_regs_bench
    import rcc_pkg::*;
;
    localparam logic [5:0] A_CFG = {`RCC_IDX_CONFIG, 2'b00};
    localparam logic [5:0] A_MSK = {`RCC_IDX_MASK, 2'b00};
    localparam logic [5:0] A_POL = {`RCC_IDX_POLICY, 2'b00};
    localparam logic [5:0] A_ST  = {`RCC_IDX_STATE, 2'b00};
    logic        clock = 1'b0;
    logic        arst_n = 1'b0;
    logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [5:0]  wbAdr = '0;
    logic [3:0]  wbSel = '0;
    logic [31:0] wbDatI = '0;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic        writeProtect = 1'b0, extClk = 1'b0;
    logic [14:0] faultVec = '0;
    logic [2:0]  poleMul, freqSel, boostSel;
    logic        freqValid, feOff, loopOn, excOn, checkState, aRun, lRun, faultAct;
    logic [15:0] checksum, rd;
    int          bad_count = 0, tests_run = 0, seed = 6795, f, k;
    int          cfgM, mskM, polM;
    int          mBit[15] = '{13, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1, 1, -1, -1};
    int          kBit[15] = '{4, 4, 4, 4, 4, -2, -1, 0, 4, 4, -2, 1, 1, 3, 2};
    logic        unm, kill;

    always #50 clock = ~clock;

    resolver_config_control_regs u_resolver_config_control_regs (
        .clock(clock), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .writeProtect(writeProtect),
        .externalClockSelect(extClk), .inputShortFlag(faultVec[0]),
        .sineOpenHighFlag(faultVec[1]), .cosineOpenHighFlag(faultVec[2]),
        .sineOpenLowFlag(faultVec[3]), .cosineOpenLowFlag(faultVec[4]),
        .loopErrorFlag(faultVec[5]), .exciterOvervoltFlag(faultVec[6]),
        .exciterUndervoltFlag(faultVec[7]), .inputOvervoltFlag(faultVec[8]),
        .inputUndervoltFlag(faultVec[9]), .calibrationFault(faultVec[10]),
        .exciterMonitorHighFlag(faultVec[11]), .exciterMonitorLowFlag(faultVec[12]),
        .digitalPinFault(faultVec[13]), .selftestFail(faultVec[14]),
        .poleMultiplier(poleMul), .exciterFreqSelect(freqSel),
        .exciterFreqValid(freqValid), .boostVoltageSelect(boostSel),
        .converterFrontEndOff(feOff), .trackingLoopOn(loopOn), .exciterOn(excOn),
        .selfCheckState(checkState), .analogSelftestRunning(aRun),
        .logicSelftestRunning(lRun), .faultActive(faultAct), .checksum(checksum)
    );

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic wb(input logic we, input logic [5:0] a, input logic [15:0] d,
                      output logic [15:0] q);
        @(posedge clock);
        wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a;
        wbSel <= 4'h3; wbDatI <= {16'h0000, d};
        do begin
            @(posedge clock);
        end while (wbAck !== 1'b1);
        q = wbDatO[15:0];
        wbCyc <= 1'b0; wbStb <= 1'b0; wbWe <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic endTest(input string nm);
        $display("test %s finished, mismatches so far %0d", nm, bad_count);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #(100 * 20000);
        bad_count++;
        report_and_stop();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        cfgM = `RCC_CONFIG_RST; mskM = 0; polM = 0;
        wb(1'b0, A_POL, 16'h0000, rd); chk("policy", 16'hc000, rd);
        wb(1'b0, A_CFG, 16'h0000, rd); chk("config", cfgM[15:0], rd);
        wb(1'b0, A_MSK, 16'h0000, rd); chk("mask", 16'h0000, rd);
        wb(1'b0, A_ST, 16'h0000, rd); chk("state", 16'h0000, rd);
        chk("checkState", 16'h0001, 16'(checkState));
        repeat (70) @(posedge clock);
        wb(1'b0, A_POL, 16'h0000, rd); chk("policy", 16'h0000, rd);
        endTest("reset");
        writeProtect <= 1'b1;
        wb(1'b1, A_CFG, 16'h0185, rd);
        wb(1'b0, A_CFG, 16'h0000, rd); chk("config", cfgM[15:0], rd);
        wb(1'b1, A_MSK, 16'h0001, rd);
        @(negedge clock);
        chk("checkState", 16'h0000, 16'(checkState));
        chk("loopOn", 16'h0001, 16'(loopOn));
        chk("excOn", 16'h0001, 16'(excOn));
        writeProtect <= 1'b0;
        wb(1'b0, A_MSK, 16'h0000, rd); chk("mask", 16'h0000, rd);
        endTest("protect");
        for (k = 0; k < 6; k++) begin
            cfgM = $random(seed) & `RCC_CONFIG_WMASK;
            mskM = $random(seed) & 16'h2ffe;
            extClk <= k[0];
            wb(1'b1, A_CFG, 16'($random(seed)) & 16'hfe40 | 16'(cfgM), rd);
            wb(1'b1, A_MSK, 16'($random(seed)) & 16'hd000 | 16'(mskM), rd);
            wb(1'b0, A_CFG, 16'h0000, rd);
            chk("config", 16'(cfgM), rd);
            chk("pole", 16'(cfgM[8:7]) + 16'h0001, 16'(poleMul));
            chk("freq", 16'(cfgM[5:3]), 16'(freqSel));
            chk("boost", 16'(cfgM[2:0]), 16'(boostSel));
            chk("freqValid", 16'(!k[0]), 16'(freqValid));
            wb(1'b0, A_MSK, 16'h0000, rd);
            chk("mask", 16'(mskM), rd);
        end
        endTest("config_mask");
        wb(1'b1, A_ST, 16'h0007, rd);
        @(negedge clock);
        chk("checkState", 16'h0001, 16'(checkState));
        wb(1'b0, A_ST, 16'h0000, rd); chk("state", 16'h0003, rd);
        wb(1'b1, A_MSK, 16'(mskM) | 16'h0001, rd);
        @(negedge clock);
        chk("checkState", 16'h0000, 16'(checkState));
        endTest("state");
        chk("checksum", 16'(cfgM ^ mskM ^ polM) ^ 16'h0003, checksum);
        wb(1'b1, A_POL, 16'hc000, rd);
        wb(1'b0, A_POL, 16'h0000, rd); chk("policy", 16'hc000, rd);
        chk("checksum", 16'(cfgM ^ mskM ^ polM) ^ 16'h0003, checksum);
        repeat (40) @(posedge clock);
        @(negedge clock);
        chk("lRun", 16'h0000, 16'(lRun));
        chk("aRun", 16'h0001, 16'(aRun));
        repeat (30) @(posedge clock);
        @(negedge clock);
        chk("aRun", 16'h0000, 16'(aRun));
        endTest("selftest");
        for (f = 0; f < 15; f++) begin
            for (k = 0; k < 2; k++) begin
                mskM = $random(seed) & 16'h2ffe;
                polM = $random(seed) & 16'h003f;
                wb(1'b1, A_MSK, 16'(mskM), rd);
                wb(1'b1, A_POL, 16'(polM), rd);
                wb(1'b1, A_ST, 16'h0003, rd);
                chk("feOff", 16'(polM[5]), 16'(feOff));
                unm = (mBit[f] < 0) || !mskM[mBit[f]];
                kill = unm && kBit[f] != -2 && (kBit[f] == -1 || !polM[kBit[f]]);
                @(posedge clock);
                faultVec[f] <= 1'b1;
                repeat (3) @(posedge clock);
                @(negedge clock);
                chk("faultAct", 16'(unm), 16'(faultAct));
                chk("excOn", 16'(!kill), 16'(excOn));
                chk("loopOn", 16'(!kill), 16'(loopOn));
                wb(1'b1, A_ST, 16'h0003, rd);
                @(negedge clock);
                chk("excOnHeld", 16'(!kill), 16'(excOn));
                @(posedge clock);
                faultVec <= '0;
                repeat (2) @(posedge clock);
            end
        end
        endTest("faults");
        wb(1'b0, 6'h3c, 16'h0000, rd); chk("unmapped", 16'h0000, rd);
        endTest("unmapped");
        report_and_stop();
    end
endmodule
